// ### sar_readout_defs.svh
// Register offsets, field positions, reset values and counts of the converter readout block.
`ifndef SAR_READOUT_DEFS_SVH
`define SAR_READOUT_DEFS_SVH

`define ADDR_W            12
`define OFS_SAMPLE        12'h000
`define OFS_STATUS        12'h004
`define OFS_RESULT        12'h008

`define WORD_BITS         16
`define SAMPLE_RESET      16'h0000
`define STAT_CALIBRATING  0
`define STAT_CONVERTING   1
`define STAT_SHUTDOWN     2
`define STAT_UNIPOLAR     3
`define STAT_EOC          4
`define STAT_HALTED       5

`define SETTLE_EDGES      2'h3
`define BIT_COUNT         5'h10
`define MSB_INDEX         4'hf
`define CAL_EDGES_DEFAULT 14000

`define SYNC_W            7
// Select and convert-start rest high and the reset pin low, so no false edge follows reset.
`define SYNC_RESET        7'h18

`endif

// ### sar_readout_pkg.sv
// Types shared by the converter readout block.
package sar_readout_pkg;

    typedef enum logic [3:0] {
        ST_OFF  = 4'b0001,
        ST_CAL  = 4'b0010,
        ST_IDLE = 4'b0100,
        ST_CONVERT_START_N = 4'b1000
    } convert_start_n_state_t;

    typedef logic [15:0] word_t;

endpackage

// ### sync_2ff.sv
// Two-stage synchroniser for a group of asynchronous input pins.
`timescale 1ns/1ps
module sync_2ff #(
    parameter int          W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= RST_VAL;
            q       <= RST_VAL;
        end else begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end
endmodule

// ### sar_readout.sv
// Conversion control and serial readout of a 16-bit successive-approximation converter.
`timescale 1ns/1ps
`include "sar_readout_defs.svh"
module sar_readout #(
    parameter int CAL_EDGES = `CAL_EDGES_DEFAULT
) (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`ADDR_W-1:0]     paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic                   convert_start_n_clk,
    input  wire logic                   sclk,
    input  wire logic                   cs_n,
    input  wire logic                   convert_start_n,
    input  wire logic                   adc_reset_n,
    input  wire logic                   range_sel_high,
    input  wire logic                   range_sel_low,
    output logic                        eoc,
    output logic                        dout,
    output logic                        dout_oe,
    output logic                        range_unipolar
);
    import sar_readout_pkg::*;

    logic [`SYNC_W-1:0] pins_s;
    logic               clk_s;
    logic               sclk_s;
    logic               cs_s;
    logic               convert_start_n_s;
    logic               rst_s;
    logic               rsh_s;
    logic               rsl_s;

    sync_2ff #(
        .W       (`SYNC_W),
        .RST_VAL (`SYNC_RESET)
    ) u_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .d     ({convert_start_n_clk, sclk, cs_n, convert_start_n, adc_reset_n,
                 range_sel_high, range_sel_low}),
        .q     (pins_s)
    );

    assign {clk_s, sclk_s, cs_s, convert_start_n_s, rst_s, rsh_s, rsl_s} = pins_s;

    convert_start_n_state_t state_ff;
    convert_start_n_state_t nxt_state;
    logic        clk_prev_ff;
    logic        sclk_prev_ff;
    logic        cs_prev_ff;
    logic        rst_prev_ff;
    logic [1:0]  since_ff;
    logic [1:0]  nxt_since;
    logic [4:0]  bit_cnt_ff;
    logic [4:0]  nxt_bit_cnt;
    logic [4:0]  rd_cnt_ff;
    logic [4:0]  nxt_rd_cnt;
    logic [13:0] cal_cnt_ff;
    logic [13:0] nxt_cal_cnt;
    logic        pending_ff;
    logic        nxt_pending;
    logic        nxt_eoc;
    logic        convert_start_n_bit_ff;
    logic        nxt_convert_start_n_bit;
    word_t       result_ff;
    word_t       nxt_result;
    word_t       sample_ff;

    wire clk_fall  = clk_prev_ff & ~clk_s;
    wire sclk_fall = sclk_prev_ff & ~sclk_s;
    wire cs_fall   = cs_prev_ff & ~cs_s;
    wire rst_rise  = ~rst_prev_ff & rst_s;
    // The window detector reports neither level while the pin floats.
    wire shutdown  = rsl_s & ~rsh_s;
    wire cal_done  = clk_fall & (cal_cnt_ff == 14'(CAL_EDGES - 1));
    wire can_start = clk_fall & pending_ff & (since_ff == `SETTLE_EDGES);
    wire bit_edge  = clk_fall & (bit_cnt_ff < `BIT_COUNT);

    function automatic logic pick_bit(input word_t w, input logic [4:0] idx);
        pick_bit = w[`MSB_INDEX - idx[3:0]];
    endfunction

    // Control sequencing: halt, calibration, acquisition wait and conversion.
    always_comb begin
        nxt_state    = state_ff;
        nxt_since    = since_ff;
        nxt_bit_cnt  = bit_cnt_ff;
        nxt_cal_cnt  = cal_cnt_ff;
        nxt_pending  = pending_ff;
        nxt_eoc      = eoc;
        nxt_convert_start_n_bit = convert_start_n_bit_ff;
        nxt_result   = result_ff;
        if (!rst_s) begin
            nxt_state   = ST_OFF;
            nxt_pending = 1'b0;
            nxt_eoc     = 1'b0;
        end else if (rst_rise) begin
            nxt_state   = ST_CAL;
            nxt_cal_cnt = '0;
            nxt_pending = 1'b0;
            nxt_eoc     = 1'b1;
        end else begin
            case (state_ff)
                ST_OFF: begin
                    nxt_eoc = 1'b0;
                    if (!shutdown) begin
                        nxt_state = ST_IDLE;
                        nxt_since = `SETTLE_EDGES;
                    end
                end
                ST_CAL: begin
                    if (cal_done) begin
                        nxt_state = ST_IDLE;
                        nxt_since = '0;
                        nxt_eoc   = 1'b0;
                    end else if (clk_fall) begin
                        nxt_cal_cnt = cal_cnt_ff + 14'h0001;
                    end
                end
                ST_IDLE: begin
                    if (shutdown) begin
                        nxt_state   = ST_OFF;
                        nxt_pending = 1'b0;
                    end else if (can_start) begin
                        nxt_state   = ST_CONVERT_START_N;
                        nxt_bit_cnt = '0;
                        nxt_pending = 1'b0;
                    end else begin
                        if (!convert_start_n_s) begin
                            nxt_pending = 1'b1;
                        end
                        if (clk_fall && since_ff != `SETTLE_EDGES) begin
                            nxt_since = since_ff + 2'h1;
                        end
                    end
                end
                ST_CONVERT_START_N: begin
                    if (bit_edge) begin
                        nxt_convert_start_n_bit = pick_bit(sample_ff, bit_cnt_ff);
                        nxt_result[`MSB_INDEX - bit_cnt_ff[3:0]] = nxt_convert_start_n_bit;
                        nxt_bit_cnt = bit_cnt_ff + 5'h01;
                        nxt_eoc     = 1'b1;
                    end else if (clk_fall) begin
                        nxt_state = ST_IDLE;
                        nxt_since = '0;
                        nxt_eoc   = 1'b0;
                    end
                end
                default: begin
                    nxt_state = ST_OFF;
                    nxt_eoc   = 1'b0;
                end
            endcase
        end
    end

    always_comb begin
        nxt_rd_cnt = rd_cnt_ff;
        if (cs_fall) begin
            nxt_rd_cnt = '0;
        end else if (sclk_fall && !cs_s && rd_cnt_ff < `BIT_COUNT) begin
            nxt_rd_cnt = rd_cnt_ff + 5'h01;
        end
    end

    wire read_bit = (nxt_rd_cnt < `BIT_COUNT) ? pick_bit(result_ff, nxt_rd_cnt) : 1'b0;
    wire nxt_dout = (state_ff == ST_CONVERT_START_N) ? nxt_convert_start_n_bit : read_bit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff     <= ST_OFF;
            since_ff     <= '0;
            bit_cnt_ff   <= '0;
            rd_cnt_ff    <= '0;
            cal_cnt_ff   <= '0;
            pending_ff   <= 1'b0;
            convert_start_n_bit_ff  <= 1'b0;
            result_ff    <= '0;
            eoc          <= 1'b0;
            dout         <= 1'b0;
            dout_oe      <= 1'b0;
            clk_prev_ff  <= 1'b0;
            sclk_prev_ff <= 1'b0;
            cs_prev_ff   <= 1'b1;
            rst_prev_ff  <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            since_ff     <= nxt_since;
            bit_cnt_ff   <= nxt_bit_cnt;
            rd_cnt_ff    <= nxt_rd_cnt;
            cal_cnt_ff   <= nxt_cal_cnt;
            pending_ff   <= nxt_pending;
            convert_start_n_bit_ff  <= nxt_convert_start_n_bit;
            result_ff    <= nxt_result;
            eoc          <= nxt_eoc;
            dout         <= nxt_dout;
            dout_oe      <= ~cs_s;
            clk_prev_ff  <= clk_s;
            sclk_prev_ff <= sclk_s;
            cs_prev_ff   <= cs_s;
            rst_prev_ff  <= rst_s;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            range_unipolar <= 1'b0;
        end else begin
            range_unipolar <= rsh_s & ~rsl_s;
        end
    end

    // APB slave with one wait state; the sample register stands in for the comparator.
    wire sel_sample = (paddr == `OFS_SAMPLE);
    wire sel_status = (paddr == `OFS_STATUS);
    wire sel_result = (paddr == `OFS_RESULT);
    wire mapped     = sel_sample | sel_status | sel_result;
    wire access     = psel & penable & ~pready;
    wire [5:0] status_w = {~rst_s, eoc, range_unipolar, state_ff == ST_OFF && rst_s,
                           state_ff == ST_CONVERT_START_N, state_ff == ST_CAL};
    logic [31:0] rd_mux;

    always_comb begin
        if (sel_sample) begin
            rd_mux = {16'h0000, sample_ff};
        end else if (sel_status) begin
            rd_mux = {26'h0, status_w};
        end else if (sel_result) begin
            rd_mux = {16'h0000, result_ff};
        end else begin
            rd_mux = 32'h00000000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready    <= 1'b0;
            pslverr   <= 1'b0;
            prdata    <= 32'h00000000;
            sample_ff <= `SAMPLE_RESET;
        end else begin
            pready  <= access;
            pslverr <= access & ~mapped;
            prdata  <= (access && !pwrite) ? rd_mux : 32'h00000000;
            if (access && pwrite && sel_sample) begin
                sample_ff <= pwdata[15:0];
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_start;
        (state_ff == ST_IDLE) ##1 (state_ff == ST_CONVERT_START_N);
    endsequence

    property p_start_gate;
        s_start |-> $past(since_ff) == 2'h3 && $past(clk_fall);
    endproperty
    a_start_gate: assert property (p_start_gate) else $error("early start");

    property p_oe_follows_cs;
        cs_s |=> !dout_oe;
    endproperty
    a_oe_follows_cs: assert property (p_oe_follows_cs) else $error("dout driven");

    property p_off_quiet;
        (state_ff == ST_OFF) |-> !eoc;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("eoc in off");

    property p_recal;
        $rose(rst_s) |=> state_ff == ST_CAL && eoc;
    endproperty
    a_recal: assert property (p_recal) else $error("no calibration");

    property p_convert_start_n_holds;
        (state_ff == ST_CONVERT_START_N && bit_cnt_ff < 5'h10 && rst_s) |=> state_ff == ST_CONVERT_START_N;
    endproperty
    a_convert_start_n_holds: assert property (p_convert_start_n_holds) else $error("convert_start_n cut");

    property p_frame;
        (state_ff == ST_CONVERT_START_N && bit_cnt_ff != 5'h00) |-> eoc;
    endproperty
    a_frame: assert property (p_frame) else $error("frame gap");

    property p_bit_order;
        (state_ff == ST_CONVERT_START_N && bit_edge && rst_s) |=>
            convert_start_n_bit_ff == $past(sample_ff[4'hf - bit_cnt_ff[3:0]]);
    endproperty
    a_bit_order: assert property (p_bit_order) else $error("bit order");

    property p_msb_first;
        (cs_fall && state_ff == ST_IDLE && !can_start) |=> dout == $past(result_ff[15]);
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("no msb");

    property p_zeros;
        (!cs_s && !cs_prev_ff && rd_cnt_ff == 5'h10 && state_ff == ST_IDLE && !can_start)
            |=> !dout;
    endproperty
    a_zeros: assert property (p_zeros) else $error("not zero");

    property p_shutdown;
        (state_ff == ST_IDLE && shutdown && rst_s && !rst_rise) |=> state_ff == ST_OFF;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("no shutdown");

    property p_cal_busy;
        (state_ff == ST_CAL) |-> eoc && !pending_ff;
    endproperty
    a_cal_busy: assert property (p_cal_busy) else $error("cal idle");
endmodule

// ### sar_host_model.sv
// Host model that clocks conversions and serial reads of the converter.
`timescale 1ns/1ps
module sar_host_model
    import sar_readout_pkg::*;
(
    output logic      convert_start_n_clk,
    output logic      sclk,
    output logic      cs_n,
    output logic      convert_start_n,
    input  wire logic eoc,
    input  wire logic dout
);
    initial begin
        convert_start_n_clk = 1'b0;
        sclk = 1'b0;
        cs_n = 1'b1;
        convert_start_n = 1'b1;
    end

    // one 320 ns cycle, parked low
    // The clock is parked low between calls, so an idle gap never holds it high.
    task automatic clk_cycle();
        convert_start_n_clk <= 1'b1;
        #120;
        convert_start_n_clk <= 1'b0;
        #200;
    endtask

    task automatic run_clk(input int n, output int high);
        high = 0;
        repeat (n) begin
            clk_cycle();
            high += (eoc === 1'b1);
        end
    endtask

    // start dropped while the clock is low
    task automatic convert(input bit poke, output int rise, output int nbits, output word_t w);
        rise = 0;
        nbits = 0;
        w = '0;
        cs_n <= 1'b0;
        convert_start_n <= 1'b0;
        // The request falls while the clock is parked low, one system cycle before it rises.
        #40;
        for (int i = 1; i <= 40; i++) begin
            clk_cycle();
            // bit taken late in the low phase
            if (eoc === 1'b1) begin
                if (rise == 0) begin
                    rise = i;
                    convert_start_n <= 1'b1;
                end
                w = {w[14:0], dout};
                nbits++;
                if (poke && nbits > 1)
                    convert_start_n <= (nbits != 8);
            end else if (rise != 0)
                break;
        end
        convert_start_n <= 1'b1;
        cs_n <= 1'b1;
    endtask

    // 320 ns read clock, pause after the burst
    task automatic read_serial(output word_t w, output int nonzero);
        nonzero = 0;
        cs_n <= 1'b0;
        #200;
        w[15] = dout;
        for (int k = 1; k <= 17; k++) begin
            sclk <= 1'b1;
            #120;
            sclk <= 1'b0;
            #200;
            if (k <= 15)
                w[15-k] = dout;
            else
                nonzero += (dout !== 1'b0);
        end
        cs_n <= 1'b1;
        #1000;
    endtask
endmodule

// ### tb.sv
// Self-checking bench of the converter readout block with its host model.
`timescale 1ns/1ps
`include "sar_readout_defs.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
    $display("mismatch at %0t: got %h expected %h", $time, (g), (e)); end end
module tb;
    import sar_readout_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        convert_start_n_clk, sclk, cs_n, convert_start_n, adc_reset_n;
    logic        range_sel_high, range_sel_low, eoc, dout, dout_oe, range_unipolar;
    wire         dout_pin;
    int          err_count, checked, rise, nbits, hi, bad;
    word_t       w;
    int          gap[4] = '{8, 0, 3, 2};
    int          lat[4] = '{2, 5, 2, 3};
    word_t       smp[4] = '{16'ha5c3, 16'h3c5a, 16'h8001, 16'h6c93};

    // A released pin with no pull shows the inverse of its last bit, so stale data fails.
    assign dout_pin = dout_oe ? dout : ~dout;

    sar_readout #(.CAL_EDGES(20)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .convert_start_n_clk, .sclk, .cs_n,
        .convert_start_n, .adc_reset_n, .range_sel_high, .range_sel_low, .eoc, .dout,
        .dout_oe, .range_unipolar);
    sar_host_model u_host (.convert_start_n_clk, .sclk, .cs_n, .convert_start_n, .eoc,
        .dout(dout_pin));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic print_verdict();
        if (err_count == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) begin
            err_count++;
            print_verdict();
        end
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        print_verdict();
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        adc_reset_n = 1'b1;
        range_sel_high = 1'b0;
        range_sel_low = 1'b0;
        err_count = 0;
        checked = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (8) @(posedge pclk);
        apb(0, `OFS_STATUS, 0);
        `CHK(rd[0], 1'b1)
        `CHK(eoc, 1'b1)
        apb(0, `OFS_SAMPLE, 0);
        `CHK(rd, 32'h0)
        apb(1, 12'h010, 32'hffff);
        `CHK({er, rd}, 33'h1_0000_0000)
        u_host.run_clk(19, hi);
        `CHK(hi, 19)
        u_host.run_clk(5, hi);
        `CHK(hi, 0)
        for (int i = 0; i < 4; i++) begin
            apb(1, `OFS_SAMPLE, {16'h0, smp[i]});
            u_host.run_clk(gap[i], hi);
            u_host.convert(1'b1, rise, nbits, w);
            `CHK(rise, lat[i])
            `CHK(nbits, 16)
            `CHK(w, smp[i])
        end
        u_host.run_clk(6, hi);
        `CHK(hi, 0)
        apb(1, `OFS_RESULT, 32'h0);
        apb(0, `OFS_RESULT, 0);
        `CHK(rd[15:0], 16'h6c93)
        `CHK(eoc, 1'b0)
        repeat (2) begin
            u_host.read_serial(w, bad);
            `CHK(w, 16'h6c93)
            `CHK(bad, 0)
        end
        `CHK(dout_oe, 1'b0)
        range_sel_high <= 1'b1;
        repeat (8) @(posedge pclk);
        apb(0, `OFS_STATUS, 0);
        `CHK({range_unipolar, rd[3:2]}, 3'b110)
        range_sel_high <= 1'b0;
        range_sel_low <= 1'b1;
        repeat (8) @(posedge pclk);
        apb(0, `OFS_STATUS, 0);
        `CHK(rd[3:2], 2'b01)
        u_host.convert(1'b0, rise, nbits, w);
        `CHK(rise, 0)
        range_sel_low <= 1'b0;
        repeat (8) @(posedge pclk);
        `CHK(range_unipolar, 1'b0)
        adc_reset_n <= 1'b0;
        repeat (8) @(posedge pclk);
        apb(0, `OFS_STATUS, 0);
        `CHK({rd[5], eoc}, 2'b10)
        u_host.convert(1'b0, rise, nbits, w);
        `CHK(rise, 0)
        adc_reset_n <= 1'b1;
        repeat (8) @(posedge pclk);
        `CHK(eoc, 1'b1)
        print_verdict();
    end
endmodule
